/* arb_pkg.sv */
package arb_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_COUNT_LOW = 4'h4;
	localparam logic [3:0] OFS_PRESCALE = 4'h8;
	// Control register bit positions
	localparam int BIT_MODE_HI = 7;
	localparam int BIT_MODE_LO = 6;
	localparam int BIT_LOST = 5;
	localparam int BIT_CLKSEL = 4;
	localparam int BIT_DONE = 3;
	localparam int BIT_RUN = 2;
	localparam int BIT_OVF = 1;
	localparam int BIT_MSB = 0;
	// Prescale register fields
	localparam int BIT_PRE_SRC = 8;
	localparam logic [7:0] PRE_DIV_RESET = 8'h00;
	localparam logic [8:0] CNT_RESET = 9'h000;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam logic [1:0] BUS_DIV_LAST = 2'h3;
	localparam logic [8:0] SAMPLE_BUS = 9'h038;
	localparam logic [8:0] SAMPLE_PRE = 9'h008;
	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {
		MODE_IDLE = 2'b00,
		MODE_MEASURE = 2'b01,
		MODE_ARBITRATE = 2'b10,
		MODE_RESERVED = 2'b11
	} arb_mode_t;

	typedef enum logic [2:0] {
		ST_WAIT = 3'b001,
		ST_COUNT = 3'b010,
		ST_STOP = 3'b100
	} arb_state_t;

	typedef struct packed {
		logic sel;
		logic write;
		logic [3:0] addr;
	} bus_req_t;
endpackage : arb_pkg

/* serial_line_arbiter_timer.sv */
// Functional notes
// RL1 - Two-bit mode: 00 idle, 01 measure, 10 arbitrate, 11 reserved.
// RL2 - Reset clears both mode bits, arbiter starts idle.
// RL3 - Lost flag read-only; cleared by writing 0 to upper mode bit, or reset.
// RL4 - Clock select 1: half prescaler output; 0: bus clock divided by four.
// RL5 - Clock select is read/write and reset clears it.
// RL6 - Any control write clears done and overflow flags.
// RL7 - Any control write clears all nine counter bits.
// RL8 - Mode 00 keeps counter in reset, no activity.
// RL9 - Running flag reads 1 while counting; reset clears it.
// RL10 - Overflow flag sets on counter overflow and stays until cleared.
// RL11 - Counter MSB in control register, low eight bits in count register.
// RL12 - Measure, divided bus clock: start on falling receive edge, stop next fall.
// RL13 - Running high while counting; done set at the second falling edge.
// RL14 - Measure, prescaler clock: start when receive low, stop on next rise.
// RL15 - Receive already low on enabling prescaler measurement starts at once.
// RL16 - Arbitration restarts counter on every rising internal transmit edge.
// RL17 - Arbitration samples receive at count 38 hex (bus) or 08 hex (prescaler).
// RL18 - Receive sampled low at sample point sets lost flag.
// RL19 - While lost flag set, transmit pin forced high.
// RL20 - Transmit low before any receive low resets counter until next rise.
// RL21 - Prescaler input is bus clock or oscillator clock by configuration bit.
// RL22 - Nine-bit counter with overflow bit, operated through control register.
// RL23 - Receive line synchronised before any edge or level detection.
module serial_line_arbiter_timer (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic rx_pin,
	input wire logic internal_transmit_out,
	input wire logic oscillator_clock,
	output logic tx_pin
);
	import arb_pkg::*;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	bus_req_t req_q;
	logic [1:0] mode_q;
	logic clksel_q;
	logic lost_q;
	logic done_q;
	logic run_q;
	logic ovf_q;
	logic [8:0] cnt_q;
	logic pre_src_q;
	logic [7:0] pre_div_q;
	logic ctl_wr;
	logic pre_wr;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_q <= '0;
		end else if (hready) begin
			req_q.sel <= hsel && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
			req_q.write <= hwrite;
			req_q.addr <= haddr[3:0];
		end
	end

	assign ctl_wr = req_q.sel && req_q.write && req_q.addr == OFS_CONTROL;
	assign pre_wr = req_q.sel && req_q.write && req_q.addr == OFS_PRESCALE;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Read data registered at the address phase, so it tracks flags one cycle late
	logic [7:0] ctl_word;
	logic [31:0] rd_word;
	logic rd_take;

	// RL11 msb in control
	always_comb begin
		ctl_word = 8'h00;
		ctl_word[BIT_MODE_HI] = mode_q[1];
		ctl_word[BIT_MODE_LO] = mode_q[0];
		ctl_word[BIT_LOST] = lost_q;
		ctl_word[BIT_CLKSEL] = clksel_q;
		ctl_word[BIT_DONE] = done_q;
		ctl_word[BIT_RUN] = run_q;
		ctl_word[BIT_OVF] = ovf_q;
		ctl_word[BIT_MSB] = cnt_q[8];
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		case (haddr[3:0])
			OFS_CONTROL: rd_word = {24'h00_0000, ctl_word};
			// RL11 low bits
			OFS_COUNT_LOW: rd_word = {24'h00_0000, cnt_q[7:0]};
			OFS_PRESCALE: rd_word = {23'h00_0000, pre_src_q, pre_div_q};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	assign rd_take = hready && hsel && htrans == HTRANS_NONSEQ && !hwrite;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_take) begin
			hrdata <= rd_word;
		end
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// RL2 mode cleared
			mode_q <= MODE_IDLE;
			// RL5 clock select cleared
			clksel_q <= 1'b0;
		end else if (ctl_wr) begin
			mode_q <= hwdata[BIT_MODE_HI:BIT_MODE_LO];
			clksel_q <= hwdata[BIT_CLKSEL];
		end
	end

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	logic mode_idle;
	logic mode_meas;
	logic mode_arb;

	// RL1 reserved code acts as idle
	assign mode_idle = mode_q == MODE_IDLE || mode_q == MODE_RESERVED;
	assign mode_meas = mode_q == MODE_MEASURE;
	assign mode_arb = mode_q == MODE_ARBITRATE;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_src_q <= 1'b0;
			pre_div_q <= PRE_DIV_RESET;
		end else if (pre_wr) begin
			pre_src_q <= hwdata[BIT_PRE_SRC];
			pre_div_q <= hwdata[7:0];
		end
	end

	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	logic [1:0] rx_sync_q;
	logic [1:0] osc_sync_q;
	logic rx_prev_q;
	logic osc_prev_q;
	logic tx_prev_q;
	logic rx_s;

	// RL23 two-stage sync
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_sync_q <= 2'b11;
			osc_sync_q <= 2'b00;
		end else begin
			rx_sync_q <= {rx_sync_q[0], rx_pin};
			osc_sync_q <= {osc_sync_q[0], oscillator_clock};
		end
	end

	// Edge history
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_prev_q <= 1'b1;
			osc_prev_q <= 1'b0;
			tx_prev_q <= 1'b1;
		end else begin
			rx_prev_q <= rx_sync_q[1];
			osc_prev_q <= osc_sync_q[1];
			tx_prev_q <= internal_transmit_out;
		end
	end
	assign rx_s = rx_sync_q[1];

	// ----------------------------------------
	// Counter clock ticks
	// ----------------------------------------
	logic [1:0] bus_div_q;
	logic [7:0] pre_cnt_q;
	logic pre_half_q;
	logic pre_src_tick;
	logic pre_out;
	logic tick;

	// RL21 prescaler source
	assign pre_src_tick = pre_src_q ? (osc_sync_q[1] && !osc_prev_q) : 1'b1;
	assign pre_out = pre_src_tick && pre_cnt_q == pre_div_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_div_q <= 2'h0;
		end else begin
			bus_div_q <= bus_div_q + 2'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_cnt_q <= 8'h00;
			pre_half_q <= 1'b0;
		end else begin
			if (pre_out) begin
				pre_cnt_q <= 8'h00;
				pre_half_q <= !pre_half_q;
			end else if (pre_src_tick) begin
				pre_cnt_q <= pre_cnt_q + 8'h01;
			end
		end
	end

	// RL4 tick source
	assign tick = clksel_q ? (pre_out && pre_half_q) : (bus_div_q == BUS_DIV_LAST);

	// ----------------------------------------
	// Arbiter engine
	// ----------------------------------------
	arb_state_t state_q;
	logic rx_fall;
	logic rx_rise;
	logic tx_rise;
	logic tx_fall;
	logic [8:0] sample_pt;

	assign rx_fall = rx_prev_q && !rx_s;
	assign rx_rise = !rx_prev_q && rx_s;
	assign tx_rise = !tx_prev_q && internal_transmit_out;
	assign tx_fall = tx_prev_q && !internal_transmit_out;
	assign sample_pt = clksel_q ? SAMPLE_PRE : SAMPLE_BUS;

	logic clr_all;
	logic meas_start;
	logic meas_stop;
	logic arb_start;
	logic arb_abort;
	logic arb_sample;
	logic cnt_step;

	// RL8 idle holds reset
	assign clr_all = ctl_wr || mode_idle;
	// RL12 start on fall
	// RL14 start on low
	// RL15 low at enable starts now
	assign meas_start = mode_meas && (clksel_q ? !rx_s : rx_fall);
	// RL13 stop edge
	assign meas_stop = mode_meas && (clksel_q ? rx_rise : rx_fall);
	// RL16 restart on rise
	assign arb_start = mode_arb && tx_rise;
	// RL20 early low resets
	assign arb_abort = mode_arb && tx_fall;
	// RL17 sample point
	assign arb_sample = mode_arb && tick && cnt_q == sample_pt;
	assign cnt_step = state_q == ST_COUNT && tick && !meas_stop && !arb_start
		&& !arb_abort && !arb_sample;

	// State and running flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_WAIT;
			run_q <= 1'b0;
		end else if (clr_all) begin
			state_q <= ST_WAIT;
			run_q <= 1'b0;
		end else begin
			case (state_q)
				ST_WAIT: begin
					if (meas_start || arb_start) begin
						state_q <= ST_COUNT;
						// RL9 running
						run_q <= 1'b1;
					end
				end
				ST_COUNT: begin
					if (meas_stop) begin
						state_q <= ST_STOP;
						run_q <= 1'b0;
					end else if (arb_start) begin
						state_q <= ST_COUNT;
					end else if (arb_abort) begin
						state_q <= ST_WAIT;
						run_q <= 1'b0;
					end else if (arb_sample) begin
						state_q <= ST_STOP;
						run_q <= 1'b0;
					end
				end
				ST_STOP: begin
					if (arb_start) begin
						state_q <= ST_COUNT;
						run_q <= 1'b1;
					end
				end
				default: begin
					state_q <= ST_WAIT;
					run_q <= 1'b0;
				end
			endcase
		end
	end

	// RL7 counter cleared
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= CNT_RESET;
		end else if (clr_all) begin
			cnt_q <= CNT_RESET;
		end else if (arb_start || (state_q == ST_COUNT && arb_abort)) begin
			cnt_q <= CNT_RESET;
		end else if (cnt_step) begin
			// RL22 nine bits plus overflow
			cnt_q <= cnt_q + 9'h001;
		end
	end

	// RL6 flags cleared
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_q <= 1'b0;
		end else if (clr_all) begin
			done_q <= 1'b0;
		end else if (state_q == ST_COUNT && meas_stop) begin
			done_q <= 1'b1;
		end
	end

	// RL10 overflow sticky
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ovf_q <= 1'b0;
		end else if (clr_all) begin
			ovf_q <= 1'b0;
		end else if (cnt_step && cnt_q == 9'h1FF) begin
			ovf_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Arbitration lost and transmit pin
	// ----------------------------------------
	logic sample_hit;
	assign sample_hit = arb_sample && state_q == ST_COUNT && !ctl_wr;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lost_q <= 1'b0;
		end else if (sample_hit && !rx_s) begin
			// RL18 set, blocked by a control write in the same cycle
			lost_q <= 1'b1;
		end else if (ctl_wr && !hwdata[BIT_MODE_HI]) begin
			// RL3 clear by upper bit
			lost_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_pin <= 1'b1;
		end else begin
			// RL19 force high
			tx_pin <= internal_transmit_out || lost_q;
		end
	end

	// RL1 mode 11 treated as idle
endmodule : serial_line_arbiter_timer

/* arb_bus_node.sv */
module arb_bus_node (
	input wire logic tx_pin,
	input wire logic dominant,
	output logic rx_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Wired-AND line: any node pulls it low
	assign rx_pin = tx_pin & ~dominant;
endmodule : arb_bus_node

/* serial_line_arbiter_timer_asserts.sv */
module serial_line_arbiter_timer_asserts
	import arb_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic internal_transmit_out,
	input wire logic tx_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic rd_q;
	logic [3:0] adr_q;
	logic ctl;
	// ----------------------------------------
	// Read data phase tracking
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q <= 1'b0;
			adr_q <= 4'h0;
		end else begin
			rd_q <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
			adr_q <= haddr[3:0];
		end
	end
	assign ctl = rd_q && adr_q == OFS_CONTROL;
	a_reset_clean: assert property ($rose(hresetn) |-> hrdata == 32'h0000_0000 && tx_pin)
		else $error("outputs not cleared by reset");
	a_tx_follows: assert property (internal_transmit_out |=> tx_pin)
		else $error("transmit pin low after high transmit");
	a_lost_tx_high: assert property (ctl && hrdata[BIT_LOST] |-> tx_pin)
		else $error("transmit pin not forced while lost");
	a_idle_quiet: assert property (ctl && hrdata[BIT_MODE_HI] == hrdata[BIT_MODE_LO] |->
		hrdata[3:0] == 4'h0)
		else $error("status active in idle mode");
	a_run_done: assert property (ctl |-> !(hrdata[BIT_RUN] && hrdata[BIT_DONE]))
		else $error("running and done together");
	a_upper_zero: assert property (rd_q |-> hrdata[31:9] == 23'h00_0000)
		else $error("read data upper bits set");
	a_unmapped_zero: assert property (rd_q && adr_q == 4'hC |-> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus response not ready and okay");
endmodule : serial_line_arbiter_timer_asserts

bind serial_line_arbiter_timer serial_line_arbiter_timer_asserts chk (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.internal_transmit_out(internal_transmit_out), .tx_pin(tx_pin));

/* serial_line_arbiter_timer_test.sv */
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected %s: expected %h, seen %h", n, e, g); end end

module serial_line_arbiter_timer_test;
	timeunit 1ns;
	timeprecision 1ps;
	import arb_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, itx = 1, osc = 0, dom = 0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r;
	logic hreadyout, hresp, rx_pin, tx_pin;
	int fail_count = 0, checks_done = 0;

	serial_line_arbiter_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.rx_pin(rx_pin), .internal_transmit_out(itx), .oscillator_clock(osc),
		.tx_pin(tx_pin));
	arb_bus_node node (.tx_pin(tx_pin), .dominant(dom), .rx_pin(rx_pin));

	initial begin
		forever #2 hclk = ~hclk;
	end
	always #20 osc = ~osc;

	// ----------------------------------------
	// Bus access tasks
	// ----------------------------------------
	task automatic end_sim;
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim

	task automatic edge_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 16);
		if (hreadyout !== 1'b1) begin
			fail_count++;
			end_sim();
		end
	endtask : edge_rdy

	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {28'h000_0000, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		hsize <= HSIZE_WORD;
		edge_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {24'h00_0000, d};
		edge_rdy();
		r = hrdata;
	endtask : bus

	task automatic rc(input string n, input logic [3:0] a, input logic [7:0] m,
		input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		`CHK(n, e, r[7:0] & m)
	endtask : rc

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		cyc(10);
		hresetn <= 1'b1;
		rc("control", OFS_CONTROL, 8'hFF, 8'h00);
		rc("count", OFS_COUNT_LOW, 8'hFF, 8'h00);
		rc("hole", 4'hC, 8'hFF, 8'h00);
		bus(1'b1, OFS_CONTROL, 8'h10);
		rc("clksel", OFS_CONTROL, 8'hFF, 8'h10);
		bus(1'b1, OFS_CONTROL, 8'h40);
		dom <= 1'b1;
		cyc(20);
		dom <= 1'b0;
		rc("running", OFS_CONTROL, 8'h0C, 8'h04);
		cyc(376);
		dom <= 1'b1;
		cyc(20);
		dom <= 1'b0;
		rc("done", OFS_CONTROL, 8'h0F, 8'h08);
		bus(1'b0, OFS_COUNT_LOW, 8'h00);
		`CHK("period", 1'b1, r >= 32'd96 && r <= 32'd103)
		bus(1'b1, OFS_CONTROL, 8'h00);
		rc("cleared", OFS_CONTROL, 8'hFF, 8'h00);
		rc("zeroed", OFS_COUNT_LOW, 8'hFF, 8'h00);
		bus(1'b1, OFS_CONTROL, 8'hC0);
		dom <= 1'b1;
		cyc(40);
		rc("reserved", OFS_CONTROL, 8'hCF, 8'hC0);
		dom <= 1'b0;
		cyc(8);
		bus(1'b1, OFS_CONTROL, 8'h40);
		dom <= 1'b1;
		cyc(2100);
		rc("overflow", OFS_CONTROL, 8'h02, 8'h02);
		dom <= 1'b0;
		bus(1'b1, OFS_CONTROL, 8'h40);
		rc("rearmed", OFS_CONTROL, 8'h0E, 8'h00);
		bus(1'b1, OFS_PRESCALE, 8'h00);
		dom <= 1'b1;
		cyc(4);
		bus(1'b1, OFS_CONTROL, 8'h50);
		cyc(200);
		dom <= 1'b0;
		cyc(10);
		rc("stopped", OFS_CONTROL, 8'h04, 8'h00);
		bus(1'b0, OFS_COUNT_LOW, 8'h00);
		`CHK("break", 1'b1, r >= 32'd97 && r <= 32'd104)
		bus(1'b1, OFS_CONTROL, 8'h80);
		itx <= 1'b0;
		cyc(8);
		itx <= 1'b1;
		dom <= 1'b1;
		cyc(260);
		rc("lost", OFS_CONTROL, 8'hE0, 8'hA0);
		rc("sample_bus", OFS_COUNT_LOW, 8'hFF, 8'h38);
		itx <= 1'b0;
		cyc(3);
		`CHK("forced", 1'b1, tx_pin)
		dom <= 1'b0;
		bus(1'b1, OFS_CONTROL, 8'h00);
		rc("unlost", OFS_CONTROL, 8'h20, 8'h00);
		bus(1'b1, OFS_CONTROL, 8'h90);
		itx <= 1'b1;
		cyc(60);
		rc("won", OFS_CONTROL, 8'h20, 8'h00);
		rc("sample_pre", OFS_COUNT_LOW, 8'hFF, 8'h08);
		bus(1'b1, OFS_CONTROL, 8'h80);
		itx <= 1'b0;
		cyc(4);
		itx <= 1'b1;
		cyc(40);
		itx <= 1'b0;
		cyc(8);
		rc("restart", OFS_COUNT_LOW, 8'hFF, 8'h00);
		end_sim();
	end
endmodule : serial_line_arbiter_timer_test
